// >>> sim/edm_bus_ctrl_test.sv
// Self-checking bench for the external data memory bus controller
`default_nettype none

module edm_bus_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys_in = 0, rst_in = 1, cyc = 0, stb = 0, we = 0;
	logic [9:0]  adr = 0;
	logic [31:0] wdat = 0, rdat;
	logic [7:0]  lp_in, lp_out, oe_n, hp, drv, irdata = 0, lat_hp;
	logic [31:0] wb_q;
	logic        ack, ale, gpio, rd_n, wr_n, busy, ireq, iwe, isel, xsel;
	logic [15:0] iaddr;
	logic [7:0]  iwdat;
	int n_fail = 0, samples_checked = 0;
	int strb, bcnt, falls, icnt, bad, ws, al, a, d, p, k;
	logic ale_q = 1;
	logic [7:0] mem_m [int];
	// ==========================================================
	// Clock, wire level, design and far side
	initial forever #5 clk_sys_in = ~clk_sys_in;
	assign lp_in = (~oe_n & lp_out) | (oe_n & drv);
	edm_bus_ctrl uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(4'h3), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .ale_out(ale), .ale_gpio_ok_out(gpio),
		.rd_n_out(rd_n), .wr_n_out(wr_n), .low_port_in(lp_in),
		.low_port_out(lp_out), .low_port_oe_n_out(oe_n),
		.high_port_out(hp), .int_req_out(ireq), .int_we_out(iwe),
		.int_extra_sel_out(isel), .int_addr_out(iaddr),
		.int_wdata_out(iwdat), .int_rdata_in(irdata), .busy_out(busy));
	edm_xram_model ram (.clk_sys_in(clk_sys_in), .ale_in(ale),
		.rd_n_in(rd_n), .wr_n_in(wr_n), .lp_in(lp_out), .hp_in(hp),
		.drv_out(drv));
	// ==========================================================
	// Monitor of strobes, drive and internal cycles
	always @(posedge clk_sys_in) begin
		ale_q <= ale;
		if (ale_q === 1'b1 && ale === 1'b0) begin
			falls++;
			lat_hp = hp;
		end
		if (busy === 1'b1) bcnt++;
		if (rd_n === 1'b0 || wr_n === 1'b0) strb++;
		if (wr_n === 1'b0 && oe_n !== 8'h00) bad++;
		if (rd_n === 1'b0 && oe_n !== 8'hff) bad++;
		if (ireq === 1'b1) begin
			icnt++;
			xsel = isel;
		end
	end
	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (e !== g) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] idx,
		input logic [31:0] v);
		int t;
		@(posedge clk_sys_in);
		cyc <= 1; stb <= 1; we <= w; adr <= {idx, 2'b00}; wdat <= v;
		for (t = 0; t < 20; t++) begin
			@(posedge clk_sys_in);
			if (ack === 1'b1) break;
		end
		if (t == 20) chk("ack", 1, 0);
		wb_q = rdat;
		cyc <= 0; stb <= 0;
		@(posedge clk_sys_in);
	endtask : wb
	task automatic go(input logic [7:0] cmd);
		strb = 0; bcnt = 0; falls = 0; icnt = 0; bad = 0; xsel = 0;
		wb(1, edm_pkg::CMD_IDX, {24'h0, cmd});
		for (int t = 0; t < 40 && busy !== 1'b0; t++)
			@(posedge clk_sys_in);
		chk("drive", 0, bad);
		chk("idle_lp", {16'h0, p[15:0]}, {16'h0, oe_n, lp_out});
	endtask : go
	task automatic summarize;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize
	initial begin
		#200000;
		n_fail++;
		summarize();
	end
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h25e0f3d0));
		repeat (2) @(posedge clk_sys_in);
		rst_in <= 0;
		wb(0, edm_pkg::AUX_IDX, 0);
		chk("aux_rst", 0, wb_q);
		wb(0, edm_pkg::HPORT_IDX, 0);
		chk("hp_rst", 8'hff, wb_q);
		wb(0, 8'h40, 0);
		chk("unmapped", 0, wb_q);
		p = $urandom;
		wb(1, edm_pkg::PIDLE_IDX, p[15:0]);
		irdata <= $urandom;
		// Linear moves over every wait and idle level setting
		for (al = 0; al < 2; al++) for (ws = 0; ws < 4; ws++) begin
			wb(1, edm_pkg::AUX_IDX, ws * 4 + al);
			chk("gpio_ok", !al, gpio);
			chk("ale_idle", !al, ale);
			a = 16'h1000 + $urandom_range(0, 16'hefff);
			d = $urandom_range(0, 255);
			wb(1, edm_pkg::ADDR_IDX, a);
			wb(1, edm_pkg::DATA_IDX, d);
			go(8'h07);
			mem_m[a] = d;
			chk("ws_wr", ws + 1, strb);
			chk("len", ws + 5, bcnt);
			chk("pulses", 1, falls);
			chk("hp_lin", a[15:8], lat_hp);
			go(8'h05);
			chk("ws_rd", ws + 1, strb);
			wb(0, edm_pkg::DATA_IDX, 0);
			chk("rd_lin", mem_m[a], wb_q[7:0]);
		end
		// Paged moves: external only map, then internal map
		wb(1, edm_pkg::AUX_IDX, 8'h02);
		p[31:16] = $urandom;
		wb(1, edm_pkg::HPORT_IDX, p[23:16]);
		a = $urandom_range(0, 255);
		wb(1, edm_pkg::ADDR_IDX, {$urandom_range(0, 255), a[7:0]});
		wb(1, edm_pkg::DATA_IDX, 8'h3c);
		go(8'h03);
		mem_m[{p[23:16], a[7:0]}] = 8'h3c;
		chk("pulses_pg", 1, falls);
		chk("hp_pg", p[23:16], lat_hp);
		wb(1, edm_pkg::ADDR_IDX, {$urandom_range(0, 255), a[7:0]});
		go(8'h01);
		wb(0, edm_pkg::DATA_IDX, 0);
		chk("rd_pg", mem_m[{p[23:16], a[7:0]}], wb_q[7:0]);
		wb(1, edm_pkg::AUX_IDX, 0);
		wb(1, edm_pkg::ADDR_IDX, a[7:0]);
		go(8'h01);
		chk("int_pulses", 0, falls);
		chk("int_cnt", 1, icnt);
		wb(0, edm_pkg::DATA_IDX, 0);
		chk("int_rd", irdata, wb_q[7:0]);
		// Stack accesses, one or two, normal and extended
		for (k = 0; k < 4; k++) begin
			wb(1, edm_pkg::AUX_IDX, (k & 1) * 16);
			go(8'h09 | ((k >> 1) * 16));
			chk("stk_cyc", ((k >> 1) + 1) * ((k & 1) + 1), icnt);
			chk("stk_sel", k & 1, xsel);
			chk("stk_pulses", 0, falls);
		end
		summarize();
	end
endmodule : edm_bus_ctrl_test

`default_nettype wire

// >>> sim/edm_xram_model.sv
// Address latch and asynchronous RAM on the far side of the bus
`default_nettype none

module edm_xram_model (
	// Bus pins
	input  wire logic       clk_sys_in,
	input  wire logic       ale_in,
	input  wire logic       rd_n_in,
	input  wire logic       wr_n_in,
	input  wire logic [7:0] lp_in,
	input  wire logic [7:0] hp_in,
	// Data the RAM puts on the low port
	output logic      [7:0] drv_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [7:0] lat_ff;
	logic [7:0] wd_ff;
	logic [7:0] last_ff = 8'h5a;
	logic       wr_q_ff = 1'b1;
	// ==========================================================
	// Latch and RAM
	// latch closes on strobe fall
	always_ff @(posedge clk_sys_in) begin
		if (ale_in)
			lat_ff <= lp_in;
		wr_q_ff <= wr_n_in;
		if (!wr_n_in)
			wd_ff <= lp_in;
		if (wr_n_in && !wr_q_ff)
			mem[{hp_in, lat_ff}] <= wd_ff;
		if (!rd_n_in)
			last_ff <= drv_out;
	end
	// Released bus shows the inverse of the last value
	assign drv_out = rd_n_in ? ~last_ff : mem[{hp_in, lat_ff}];
endmodule : edm_xram_model

`default_nettype wire

// >>> verilog/edm_bus_ctrl.sv
// External data memory bus controller: register slave and sequencer
//
// Chosen here: the Wishbone register port.
`default_nettype none
// How it works
// - Paged moves emit only an 8-bit address on the low port.
// - Each external access pulses the latch strobe while address is out.
// - In paged mode the high port shows only the software value.
// - Extension select routes stack to extra RAM (4K) else indirect (256).
// - Extended stack adds one extra cycle per stack access.
// - Wait select 0..3 gives strobe width 1..4 cycles.
// - External-only map sends every move address to the bus.
// - Idle latch strobe is high with idle level bit 0, low with 1.
// - Latch strobe pulse is always active high.
// - Latch strobe moves only during external accesses.
// - Latch strobe pin is free for general use only with idle bit 0.
// - Low port drives push-pull while presenting address or write data.
// - Low port is released while read data is sampled.
// - Outside accesses the low port follows its own idle setting.
// - Address on both ports is stable at latch strobe falling edge.
// - Linear moves hold the upper address on the high port throughout.

module edm_bus_ctrl #(
	parameter logic [15:0] INT_MAP_TOP = 16'h0fff
) (
	// Clock and reset
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	// Wishbone slave
	input  wire logic        wb_cyc_in,
	input  wire logic        wb_stb_in,
	input  wire logic        wb_we_in,
	input  wire logic [9:0]  wb_adr_in,
	input  wire logic [3:0]  wb_sel_in,
	input  wire logic [31:0] wb_dat_in,
	output logic      [31:0] wb_dat_out,
	output logic             wb_ack_out,
	// External bus pins
	output logic             ale_out,
	output logic             ale_gpio_ok_out,
	output logic             rd_n_out,
	output logic             wr_n_out,
	input  wire logic [7:0]  low_port_in,
	output logic      [7:0]  low_port_out,
	output logic      [7:0]  low_port_oe_n_out,
	output logic      [7:0]  high_port_out,
	// Internal memory port
	output logic             int_req_out,
	output logic             int_we_out,
	output logic             int_extra_sel_out,
	output logic      [15:0] int_addr_out,
	output logic      [7:0]  int_wdata_out,
	input  wire logic [7:0]  int_rdata_in,
	// Status
	output logic             busy_out
);

	edm_ctl_if ctl ();

	edm_pkg::edm_state_type state_ff, nxt_state;

	logic [4:0]  aux_ff;
	logic [7:0]  hport_ff;
	logic [15:0] addr_ff;
	logic [7:0]  data_ff;
	logic [7:0]  rdata_ff;
	logic [7:0]  pidle_val_ff;
	logic [7:0]  pidle_oen_ff;
	logic        cur_wr_ff;
	logic        cur_lin_ff;
	logic        cur_stk_ff;
	logic        cur_int_ff;
	logic [1:0]  cur_ws_ff;
	logic [15:0] cur_addr_ff;
	logic [7:0]  cur_data_ff;
	logic [2:0]  stk_cnt_ff;
	logic [1:0]  hold_ff;
	logic [7:0]  lp_meta_ff;
	logic [7:0]  lp_sync_ff;
	logic        ack_ff;
	logic [31:0] dat_ff;
	logic        ale_ff;
	logic        rd_n_ff;
	logic        wr_n_ff;
	logic [7:0]  lp_out_ff;
	logic [7:0]  lp_oen_ff;
	logic [7:0]  hp_out_ff;
	logic        int_req_ff;
	logic        int_we_ff;
	logic        int_xsel_ff;
	logic [15:0] int_addr_ff;

	// ==========================================================
	// Register bus decode
	wire        bus_acc = wb_cyc_in && wb_stb_in && !ack_ff;
	wire        bus_wr  = bus_acc && wb_we_in;
	wire [7:0]  reg_idx = wb_adr_in[9:2];
	wire        hit_aux = (reg_idx == edm_pkg::AUX_IDX);
	wire        hit_hp  = (reg_idx == edm_pkg::HPORT_IDX);
	wire        hit_adr = (reg_idx == edm_pkg::ADDR_IDX);
	wire        hit_dat = (reg_idx == edm_pkg::DATA_IDX);
	wire        hit_cmd = (reg_idx == edm_pkg::CMD_IDX);
	wire        hit_pid = (reg_idx == edm_pkg::PIDLE_IDX);
	wire        lane0   = bus_wr && wb_sel_in[0];
	wire        lane1   = bus_wr && wb_sel_in[1];
	wire        idle    = (state_ff == edm_pkg::ST_IDLE);
	wire        start   = lane0 && hit_cmd && idle
		&& wb_dat_in[edm_pkg::CMD_START_BIT];

	// Auxiliary control fields
	wire        stack_extension_select  = aux_ff[edm_pkg::AUX_STACK_EXTENSION_SELECT_BIT];
	wire [1:0]  ws    = aux_ff[edm_pkg::AUX_WS_LSB +: 2];
	wire        external_only_map = aux_ff[edm_pkg::AUX_EXTERNAL_ONLY_MAP_BIT];
	wire        latch_strobe_idle_level  = aux_ff[edm_pkg::AUX_LATCH_STROBE_IDLE_LEVEL_BIT];

	// Request fields: command bits fresh from the bus, address and data from the registers on start, else latched (req_two is never latched)
	wire        req_wr   = start ? wb_dat_in[edm_pkg::CMD_WRITE_BIT]
		: cur_wr_ff;
	wire        req_lin  = start ? wb_dat_in[edm_pkg::CMD_LIN_BIT]
		: cur_lin_ff;
	wire        req_stk  = start ? wb_dat_in[edm_pkg::CMD_STACK_BIT]
		: cur_stk_ff;
	wire        req_two  = wb_dat_in[edm_pkg::CMD_TWO_BIT];
	wire [15:0] req_addr = start ? addr_ff : cur_addr_ff;
	wire [7:0]  req_data = start ? data_ff : cur_data_ff;

	// ==========================================================
	// paged moves see only the low address byte
	wire [15:0] map_addr = req_lin ? req_addr : {8'h00, req_addr[7:0]};

	// Map decoder and strobe timer links
	assign ctl.map_addr  = map_addr;
	assign ctl.map_top   = INT_MAP_TOP;
	assign ctl.map_external_only_map = external_only_map;
	assign ctl.map_stack = req_stk;
	assign ctl.map_stack_extension_select  = stack_extension_select;
	assign ctl.tmr_load  = (state_ff == edm_pkg::ST_TURN);
	assign ctl.tmr_ws    = cur_ws_ff;

	edm_map_dec u_map (
		.ctl (ctl.map)
	);

	edm_strobe_tmr u_tmr (
		.clk_sys_in (clk_sys_in),
		.rst_in     (rst_in),
		.ctl        (ctl.tmr)
	);

	// one or two accesses, doubled on the extended stack
	wire [2:0]  stk_base = req_two ? 3'h2 : 3'h1;
	wire [2:0]  stk_load = stack_extension_select ? {stk_base[1:0], 1'b0} : stk_base;

	// ==========================================================
	// sequencer: latch, turnaround, strobe, release
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			edm_pkg::ST_IDLE: begin
				if (start && req_stk) begin
					nxt_state = edm_pkg::ST_STACK;
				end else if (start && ctl.map_ext) begin
					nxt_state = edm_pkg::ST_ALE;
				end else if (start) begin
					nxt_state = edm_pkg::ST_INT;
				end
			end
			edm_pkg::ST_ALE:    nxt_state = edm_pkg::ST_TURN;
			edm_pkg::ST_TURN:   nxt_state = edm_pkg::ST_STROBE;
			edm_pkg::ST_STROBE: begin
				if (ctl.tmr_last) begin
					nxt_state = edm_pkg::ST_HOLD;
				end
			end
			edm_pkg::ST_HOLD: begin
				if (hold_ff == edm_pkg::HOLD_LAST) begin
					nxt_state = edm_pkg::ST_IDLE;
				end
			end
			edm_pkg::ST_INT:    nxt_state = edm_pkg::ST_IDLE;
			edm_pkg::ST_STACK: begin
				if (stk_cnt_ff == 3'h1) begin
					nxt_state = edm_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// ==========================================================
	// Pin values for the coming cycle
	wire ext_nxt = (nxt_state == edm_pkg::ST_ALE)
		|| (nxt_state == edm_pkg::ST_TURN)
		|| (nxt_state == edm_pkg::ST_STROBE)
		|| (nxt_state == edm_pkg::ST_HOLD);
	wire ale_nxt = (nxt_state == edm_pkg::ST_ALE);
	wire stb_nxt = (nxt_state == edm_pkg::ST_STROBE);

	// high pulse, idle level only outside accesses
	wire        nxt_ale = ale_nxt || (!ext_nxt && !latch_strobe_idle_level);
	// strobe low for the whole stretched window
	wire        nxt_rd_n = !(stb_nxt && !req_wr);
	wire        nxt_wr_n = !(stb_nxt && req_wr);
	// forced drive, release for reads, else idle setup
	wire [7:0]  nxt_lp_out = ale_nxt ? map_addr[7:0]
		: ext_nxt ? req_data : pidle_val_ff;
	wire [7:0]  nxt_lp_oen = ale_nxt ? 8'h00
		: ext_nxt ? (req_wr ? 8'h00 : 8'hff) : pidle_oen_ff;
	// upper byte only for linear moves, else software page
	wire [7:0]  nxt_hp_out = (ext_nxt && req_lin) ? req_addr[15:8]
		: hport_ff;
	wire        stk_nxt = (nxt_state == edm_pkg::ST_STACK);
	wire        nxt_int_req = stk_nxt || (nxt_state == edm_pkg::ST_INT);
	wire [15:0] nxt_int_addr = !stk_nxt ? req_addr
		: ctl.map_extra ? {4'h0, req_addr[edm_pkg::XRAM_AW-1:0]}
		: {8'h00, req_addr[edm_pkg::IRAM_AW-1:0]};

	// ==========================================================
	// State and sequence counters
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			state_ff   <= edm_pkg::ST_IDLE;
			stk_cnt_ff <= 3'h0;
			hold_ff    <= 2'h0;
		end else begin
			state_ff   <= nxt_state;
			stk_cnt_ff <= start ? stk_load : stk_cnt_ff - 3'(stk_nxt);
			hold_ff    <= (state_ff == edm_pkg::ST_HOLD)
				? hold_ff + 2'h1 : 2'h0;
		end
	end

	// Request latches taken at start
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			{cur_wr_ff, cur_lin_ff, cur_stk_ff, cur_int_ff} <= 4'h0;
			cur_ws_ff   <= 2'h0;
			cur_addr_ff <= 16'h0000;
			cur_data_ff <= 8'h00;
		end else if (start) begin
			{cur_wr_ff, cur_lin_ff, cur_stk_ff} <= {req_wr, req_lin, req_stk};
			cur_int_ff  <= !ctl.map_ext;
			cur_ws_ff   <= ws;
			cur_addr_ff <= addr_ff;
			cur_data_ff <= data_ff;
		end
	end

	// Two-flop synchroniser on the low port inputs
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			lp_meta_ff <= 8'h00;
			lp_sync_ff <= 8'h00;
		end else begin
			lp_meta_ff <= low_port_in;
			lp_sync_ff <= lp_meta_ff;
		end
	end

	// Read data: bus pin at strobe end, taken two cycles later, or internal memory
	wire cap_ext = (state_ff == edm_pkg::ST_HOLD)
		&& (hold_ff == edm_pkg::HOLD_LAST) && !cur_wr_ff;
	wire cap_int = (state_ff == edm_pkg::ST_INT) && !cur_wr_ff;
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rdata_ff <= 8'h00;
		end else if (cap_ext) begin
			rdata_ff <= lp_sync_ff;
		end else if (cap_int) begin
			rdata_ff <= int_rdata_in;
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			aux_ff       <= edm_pkg::AUX_RESET;
			hport_ff     <= edm_pkg::HPORT_RESET;
			addr_ff      <= 16'h0000;
			data_ff      <= 8'h00;
			pidle_val_ff <= edm_pkg::PIDLE_VAL_RST;
			pidle_oen_ff <= edm_pkg::PIDLE_OEN_RST;
		end else begin
			if (lane0 && hit_aux) aux_ff <= wb_dat_in[4:0];
			if (lane0 && hit_hp)  hport_ff <= wb_dat_in[7:0];
			if (lane0 && hit_adr) addr_ff[7:0] <= wb_dat_in[7:0];
			if (lane1 && hit_adr) addr_ff[15:8] <= wb_dat_in[15:8];
			if (lane0 && hit_dat) data_ff <= wb_dat_in[7:0];
			if (lane0 && hit_pid) pidle_val_ff <= wb_dat_in[7:0];
			if (lane1 && hit_pid) pidle_oen_ff <= wb_dat_in[15:8];
		end
	end

	// Read mux; unmapped indices read as zero
	wire [31:0] sts_word = {29'h0, stack_extension_select, cur_int_ff, !idle};
	wire [31:0] rd_word = hit_aux ? {27'h0, aux_ff}
		: hit_hp  ? {24'h0, hport_ff}
		: hit_adr ? {16'h0, addr_ff}
		: hit_dat ? {24'h0, rdata_ff}
		: hit_cmd ? sts_word
		: hit_pid ? {16'h0, pidle_oen_ff, pidle_val_ff}
		: 32'h0000_0000;

	// Single-wait acknowledge, dropped the cycle after
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ack_ff <= 1'b0;
			dat_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= bus_acc;
			dat_ff <= bus_acc ? rd_word : 32'h0000_0000;
		end
	end

	// ==========================================================
	// Registered pin and port outputs
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ale_ff      <= 1'b1;
			rd_n_ff     <= 1'b1;
			wr_n_ff     <= 1'b1;
			lp_out_ff   <= edm_pkg::PIDLE_VAL_RST;
			lp_oen_ff   <= edm_pkg::PIDLE_OEN_RST;
			hp_out_ff   <= edm_pkg::HPORT_RESET;
			int_req_ff  <= 1'b0;
			int_we_ff   <= 1'b0;
			int_xsel_ff <= 1'b0;
			int_addr_ff <= 16'h0000;
		end else begin
			ale_ff      <= nxt_ale;
			rd_n_ff     <= nxt_rd_n;
			wr_n_ff     <= nxt_wr_n;
			lp_out_ff   <= nxt_lp_out;
			lp_oen_ff   <= nxt_lp_oen;
			hp_out_ff   <= nxt_hp_out;
			int_req_ff  <= nxt_int_req;
			int_we_ff   <= nxt_int_req && req_wr;
			int_xsel_ff <= stk_nxt && ctl.map_extra;
			int_addr_ff <= nxt_int_addr;
		end
	end

	// pin usable as general I/O only with idle bit clear
	logic gpio_ok_ff;
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			gpio_ok_ff <= 1'b1;
		end else begin
			gpio_ok_ff <= !latch_strobe_idle_level;
		end
	end

	// Output wiring
	assign wb_ack_out        = ack_ff;
	assign wb_dat_out        = dat_ff;
	assign ale_out           = ale_ff;
	assign ale_gpio_ok_out   = gpio_ok_ff;
	assign rd_n_out          = rd_n_ff;
	assign wr_n_out          = wr_n_ff;
	assign low_port_out      = lp_out_ff;
	assign low_port_oe_n_out = lp_oen_ff;
	assign high_port_out     = hp_out_ff;
	assign int_req_out       = int_req_ff;
	assign int_we_out        = int_we_ff;
	assign int_extra_sel_out = int_xsel_ff;
	assign int_addr_out      = int_addr_ff;
	assign int_wdata_out     = cur_data_ff;
	assign busy_out          = !idle;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	logic [2:0] strb_len_ff;
	logic [2:0] stk_len_ff;
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			strb_len_ff <= 3'h0;
			stk_len_ff  <= 3'h0;
		end else begin
			strb_len_ff <= (rd_n_ff && wr_n_ff) ? 3'h0 : strb_len_ff + 3'h1;
			stk_len_ff  <= (state_ff == edm_pkg::ST_STACK)
				? stk_len_ff + 3'h1 : 3'h0;
		end
	end

	strobe_width_a: assert property (
		$rose(rd_n_ff && wr_n_ff) |-> strb_len_ff == 3'(cur_ws_ff) + 3'h1)
		else $error("strobe width differs from wait select");
	ale_idle_a: assert property (
		(idle && $past(idle) && !$past(start)) |-> ale_ff == !$past(latch_strobe_idle_level))
		else $error("latch strobe idle level wrong");
	ale_pulse_a: assert property (
		$rose(state_ff == edm_pkg::ST_ALE) |-> ale_ff && !lp_oen_ff[0]
		##1 !ale_ff)
		else $error("latch strobe pulse missing");
	addr_stable_a: assert property (
		$fell(ale_ff) && !idle
		|-> $stable(hp_out_ff) && $past(lp_oen_ff) == 8'h00)
		else $error("address unstable at latch fall");
	port_release_a: assert property (
		!rd_n_ff |-> lp_oen_ff == 8'hff && wr_n_ff)
		else $error("low port driven during read");
	port_drive_a: assert property (
		!wr_n_ff |-> lp_oen_ff == 8'h00 && lp_out_ff == cur_data_ff)
		else $error("low port not driving write data");
	page_sw_a: assert property (
		(!idle && !cur_lin_ff && $past(!idle)) |-> hp_out_ff == hport_ff)
		else $error("high port changed by paged access");
	linear_high_a: assert property (
		(state_ff == edm_pkg::ST_STROBE && cur_lin_ff)
		|-> hp_out_ff == cur_addr_ff[15:8])
		else $error("upper address missing in linear access");
	stack_pen_a: assert property (
		$fell(state_ff == edm_pkg::ST_STACK) && stack_extension_select
		|-> stk_len_ff[0] == 1'b0 && stk_len_ff != 3'h0)
		else $error("extended stack penalty missing");

endmodule : edm_bus_ctrl

`default_nettype wire

// >>> verilog/edm_ctl_if.sv
// Control links between the sequencer, strobe timer and map decoder
`default_nettype none

interface edm_ctl_if;
	logic        tmr_load;
	logic [1:0]  tmr_ws;
	logic        tmr_last;
	logic [15:0] map_addr;
	logic [15:0] map_top;
	logic        map_external_only_map;
	logic        map_stack;
	logic        map_stack_extension_select;
	logic        map_ext;
	logic        map_extra;

	modport ctrl (output tmr_load, tmr_ws, map_addr, map_top, map_external_only_map,
		map_stack, map_stack_extension_select, input tmr_last, map_ext, map_extra);
	modport tmr (input tmr_load, tmr_ws, output tmr_last);
	modport map (input map_addr, map_top, map_external_only_map, map_stack, map_stack_extension_select,
		output map_ext, map_extra);
endinterface : edm_ctl_if

`default_nettype wire

// >>> verilog/edm_map_dec.sv
// Address map decode: internal memory, external bus or stack space
`default_nettype none

module edm_map_dec (
	// Sequencer link
	edm_ctl_if.map ctl
);

	// ==========================================================
	// bypass or mapped internal range
	assign ctl.map_ext = !ctl.map_stack
		&& (ctl.map_external_only_map || (ctl.map_addr > ctl.map_top));

	assign ctl.map_extra = ctl.map_stack && ctl.map_stack_extension_select;

endmodule : edm_map_dec

`default_nettype wire

// >>> verilog/edm_pkg.sv
// Shared constants and types for the external data memory bus controller
`default_nettype none

package edm_pkg;

	// ==========================================================
	// Register indices (byte address is four times the index)
	localparam logic [7:0] AUX_IDX   = 8'h8e;
	localparam logic [7:0] HPORT_IDX = 8'h90;
	localparam logic [7:0] ADDR_IDX  = 8'h91;
	localparam logic [7:0] DATA_IDX  = 8'h92;
	localparam logic [7:0] CMD_IDX   = 8'h93;
	localparam logic [7:0] PIDLE_IDX = 8'h94;

	// ==========================================================
	// Auxiliary control fields and reset values
	localparam int         AUX_STACK_EXTENSION_SELECT_BIT  = 4;
	localparam int         AUX_WS_LSB    = 2;
	localparam int         AUX_EXTERNAL_ONLY_MAP_BIT = 1;
	localparam int         AUX_LATCH_STROBE_IDLE_LEVEL_BIT  = 0;
	localparam logic [4:0] AUX_RESET     = 5'h00;
	localparam logic [7:0] HPORT_RESET   = 8'hff;
	localparam logic [7:0] PIDLE_VAL_RST = 8'hff;
	localparam logic [7:0] PIDLE_OEN_RST = 8'hff;

	// ==========================================================
	// Command fields (write) and status fields (read)
	localparam int CMD_START_BIT = 0;
	localparam int CMD_WRITE_BIT = 1;
	localparam int CMD_LIN_BIT   = 2;
	localparam int CMD_STACK_BIT = 3;
	localparam int CMD_TWO_BIT   = 4;
	localparam int STS_BUSY_BIT  = 0;
	localparam int STS_INT_BIT   = 1;
	localparam int STS_STACK_EXTENSION_SELECT_BIT  = 2;

	// ==========================================================
	// Memory sizes and sequencing
	localparam int         IRAM_AW    = 8;
	localparam int         XRAM_AW    = 12;
	localparam logic [1:0] HOLD_LAST  = 2'h1;

	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE, ST_ALE, ST_TURN, ST_STROBE, ST_HOLD, ST_INT, ST_STACK
	} edm_state_type;

endpackage : edm_pkg

`default_nettype wire

// >>> verilog/edm_strobe_tmr.sv
// Strobe width counter for wait state stretching
`default_nettype none

module edm_strobe_tmr (
	// Clock and reset
	input  wire logic clk_sys_in,
	input  wire logic rst_in,
	// Sequencer link
	edm_ctl_if.tmr    ctl
);

	logic [1:0] cnt_ff;

	// ==========================================================
	// Load wait count, then count down to the last strobe cycle
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			cnt_ff <= 2'h0;
		end else if (ctl.tmr_load) begin
			cnt_ff <= ctl.tmr_ws;
		end else if (cnt_ff != 2'h0) begin
			cnt_ff <= cnt_ff - 2'h1;
		end
	end

	assign ctl.tmr_last = (cnt_ff == 2'h0);

endmodule : edm_strobe_tmr

`default_nettype wire
